// ===== acvr_pkg.sv
// acvr_pkg: shared constants for the ac volt range/resolution settings block.
// assumes a single 50 MHz clock and a plain strobed register port.
package acvr_pkg;

    // register byte offsets
    localparam logic [7:0] ACVR_CMD_OFS = 8'h00;
    localparam logic [7:0] ACVR_ANS_OFS = 8'h04;
    localparam logic [7:0] ACVR_SET_OFS = 8'h08;
    localparam logic [7:0] ACVR_STAT_OFS = 8'h0c;
    localparam logic [7:0] ACVR_MASK_OFS = 8'h10;

    // command word fields
    localparam int ACVR_OP_LSB = 0;
    localparam int ACVR_SEL_LSB = 4;
    localparam int ACVR_ARG_LSB = 8;

    // status / mask bit positions
    localparam int ACVR_EV_ANS = 0;
    localparam int ACVR_EV_CONFLICT = 1;
    localparam int ACVR_EV_PARAM = 2;
    localparam int ACVR_EV_AUTOSW = 3;

    typedef enum logic [3:0] {
        ACVR_OP_NOP = 4'h0,
        ACVR_OP_RANGE_SET = 4'h1,
        ACVR_OP_RANGE_QRY = 4'h2,
        ACVR_OP_AUTO_SET = 4'h3,
        ACVR_OP_AUTO_QRY = 4'h4,
        ACVR_OP_RES_SET = 4'h5,
        ACVR_OP_RES_QRY = 4'h6,
        ACVR_OP_CONF = 4'h7
    } acvr_op_t;

    // argument selectors: plain number, minimum, maximum, default_range_selector
    typedef enum logic [1:0] {
        ACVR_SEL_NUM = 2'h0,
        ACVR_SEL_MIN = 2'h1,
        ACVR_SEL_MAX = 2'h2,
        ACVR_SEL_DEF = 2'h3
    } acvr_sel_t;

    // range indices: 100mV, 1V, 10V, 100V, 300V
    localparam logic [2:0] ACVR_RNG_MIN = 3'h0;
    localparam logic [2:0] ACVR_RNG_DEF = 3'h2;
    localparam logic [2:0] ACVR_RNG_MAX = 3'h4;
    localparam logic [23:0] ACVR_FS_MV_0 = 24'h000064;
    localparam logic [23:0] ACVR_FS_MV_1 = 24'h0003e8;
    localparam logic [23:0] ACVR_FS_MV_2 = 24'h002710;
    localparam logic [23:0] ACVR_FS_MV_3 = 24'h0186a0;
    localparam logic [23:0] ACVR_FS_MV_4 = 24'h0493e0;

    // resolution: step 0 best .. step 2 worst; exponent = range decade - 6 + step
    localparam logic [1:0] ACVR_RES_STEP_MAX = 2'h2;
    localparam logic [7:0] ACVR_RES_BEST_OFS = 8'h06;
    // reset: 10V range at 1e-4 V
    localparam logic [1:0] ACVR_RES_STEP_RST = 2'h1;
    localparam logic ACVR_AUTO_RST = 1'b1;
    localparam logic [3:0] ACVR_MASK_RST = 4'h0;

endpackage : acvr_pkg

// ===== acvr_ctl.sv
// acvr_ctl: command interpreter holding ac volt range, autorange and resolution.
// assumes commands arrive pre-parsed as words on the register port, and the
// measurement path (same clock) supplies a range request before each reading.
//
// Behaviour
// - five ranges 100mV..300V plus min, max and default selectors accepted
// - numeric range argument picks the smallest range holding that voltage
// - min selector picks 100mV, max selector picks 300V
// - any explicit fixed range selection turns autorange off
// - range command overrides configure range and picks matching resolution
// - after reset the range is 10V
// - range query returns standard range value; min gives 100mV, max 300V
// - autorange takes boolean, numerals 0 and 1 mean off and on
// - with autorange on, range is set from an input of 0..4 before each measurement; a larger input leaves it unchanged
// - after reset autorange is on
// - autorange query answers 1 when on, 0 when off
// - resolution min gives best value, max gives worst, for current range
// - resolution follows each range that autoranging picks
// - resolution command overrides configure resolution
// - resolution not combinable with current settings flags a conflict
// - resolution query: present value, or min/max for current range
module acvr_ctl
    import acvr_pkg::*;
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic reset_n,
    // register port
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    // measurement path
    input wire logic meas_req,
    input wire logic [2:0] meas_need_range,
    output logic meas_go,
    output logic [2:0] range_idx,
    output logic [7:0] res_exp,
    output logic autorange_on,
    // interrupt
    output logic irq
);

    ////////////////////////////////////////////////////////////////////////////
    // helpers

    // full scale of the five ranges
    function automatic logic [23:0] fs_mv(input logic [2:0] idx);
        unique case (idx)
            3'h0: fs_mv = ACVR_FS_MV_0;
            3'h1: fs_mv = ACVR_FS_MV_1;
            3'h2: fs_mv = ACVR_FS_MV_2;
            3'h3: fs_mv = ACVR_FS_MV_3;
            default: fs_mv = ACVR_FS_MV_4;
        endcase
    endfunction : fs_mv

    // decade of the range; 300V shares the 100V decade
    function automatic logic [7:0] rng_dec(input logic [2:0] idx);
        unique case (idx)
            3'h0: rng_dec = 8'hff;
            3'h1: rng_dec = 8'h00;
            3'h2: rng_dec = 8'h01;
            default: rng_dec = 8'h02;
        endcase
    endfunction : rng_dec

    function automatic logic [7:0] best_exp(input logic [2:0] idx);
        best_exp = rng_dec(idx) - ACVR_RES_BEST_OFS;
    endfunction : best_exp

    ////////////////////////////////////////////////////////////////////////////
    // reset release

    logic rst_meta_q;
    logic rst_n_q;

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            rst_meta_q <= 1'b0;
            rst_n_q <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_n_q <= rst_meta_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // command decode

    logic cmd_wr;
    acvr_op_t op;
    acvr_sel_t sel;
    logic [23:0] arg;

    assign cmd_wr = reg_wr && (reg_addr == ACVR_CMD_OFS);
    assign op = acvr_op_t'(reg_wdata[ACVR_OP_LSB +: 4]);
    assign sel = acvr_sel_t'(reg_wdata[ACVR_SEL_LSB +: 2]);
    assign arg = reg_wdata[ACVR_ARG_LSB +: 24];

    logic [2:0] range_q;
    logic auto_q;
    logic [1:0] res_step_q;

    // requested range from argument; num_ok low when above the top range
    logic [2:0] arg_rng;
    logic num_ok;

    always_comb begin
        arg_rng = ACVR_RNG_MAX;
        num_ok = (arg <= ACVR_FS_MV_4);
        for (int i = 4; i >= 0; i--) begin
            if (arg <= fs_mv(3'(i))) begin
                arg_rng = 3'(i);
            end
        end
        unique case (sel)
            ACVR_SEL_MIN: arg_rng = ACVR_RNG_MIN;
            ACVR_SEL_MAX: arg_rng = ACVR_RNG_MAX;
            ACVR_SEL_DEF: arg_rng = ACVR_RNG_DEF;
            ACVR_SEL_NUM: arg_rng = arg_rng;
        endcase
        if (sel != ACVR_SEL_NUM) begin
            num_ok = 1'b1;
        end
    end

    // explicit resolution exponent checked against current range
    logic [7:0] arg_exp;
    logic [7:0] exp_ofs;
    logic res_fits;

    assign arg_exp = arg[7:0];
    assign exp_ofs = arg_exp - best_exp(range_q);
    assign res_fits = (exp_ofs <= 8'(ACVR_RES_STEP_MAX));

    ////////////////////////////////////////////////////////////////////////////
    // settings

    logic auto_switch;

    // take the requested range ahead of the reading
    assign auto_switch = meas_req && auto_q && (meas_need_range <= ACVR_RNG_MAX)
        && (meas_need_range != range_q);

    always_ff @(posedge ref_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            range_q <= ACVR_RNG_DEF;
        end else if (cmd_wr && (op == ACVR_OP_RANGE_SET || op == ACVR_OP_CONF) && num_ok) begin
            range_q <= arg_rng;
        end else if (auto_switch) begin
            range_q <= meas_need_range;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            auto_q <= ACVR_AUTO_RST;
        end else if (cmd_wr && (op == ACVR_OP_RANGE_SET || op == ACVR_OP_CONF) && num_ok) begin
            auto_q <= 1'b0;
        end else if (cmd_wr && op == ACVR_OP_AUTO_SET && arg <= 24'h000001) begin
            auto_q <= arg[0];
        end
    end

    // resolution kept as a step within the range, so it tracks every range
    // change, whether commanded or picked by autoranging
    always_ff @(posedge ref_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            res_step_q <= ACVR_RES_STEP_RST;
        end else if (cmd_wr && (op == ACVR_OP_RES_SET || op == ACVR_OP_CONF)) begin
            // min best, max worst, explicit value if it fits
            unique case (sel)
                ACVR_SEL_MIN: res_step_q <= 2'h0;
                ACVR_SEL_MAX: res_step_q <= ACVR_RES_STEP_MAX;
                ACVR_SEL_NUM: begin
                    if (op == ACVR_OP_RES_SET && res_fits) begin
                        res_step_q <= exp_ofs[1:0];
                    end
                end
                ACVR_SEL_DEF: res_step_q <= res_step_q;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // query answers

    logic ans_ev;
    logic [31:0] ans_d;
    logic [31:0] ans_q;
    logic [7:0] best_now;
    logic [7:0] worst_now;

    // a select on a call result is not legal, so name the exponents first
    assign best_now = best_exp(range_q);
    assign worst_now = best_now + 8'(ACVR_RES_STEP_MAX);

    always_comb begin
        ans_ev = 1'b0;
        ans_d = ans_q;
        if (cmd_wr) begin
            unique case (op)
                ACVR_OP_RANGE_QRY: begin
                    ans_ev = 1'b1;
                    unique case (sel)
                        ACVR_SEL_MIN: ans_d = {8'h00, fs_mv(ACVR_RNG_MIN)};
                        ACVR_SEL_MAX: ans_d = {8'h00, fs_mv(ACVR_RNG_MAX)};
                        default: ans_d = {8'h00, fs_mv(range_q)};
                    endcase
                end
                ACVR_OP_AUTO_QRY: begin
                    ans_ev = 1'b1;
                    // one when on, zero when off
                    ans_d = {31'h0, auto_q};
                end
                ACVR_OP_RES_QRY: begin
                    ans_ev = 1'b1;
                    // present, best or worst, as signed decade exponent
                    unique case (sel)
                        ACVR_SEL_MIN: ans_d = {{24{best_now[7]}}, best_now};
                        ACVR_SEL_MAX: ans_d = {{24{worst_now[7]}}, worst_now};
                        default: ans_d = {{24{res_exp[7]}}, res_exp};
                    endcase
                end
                default: begin
                    ans_ev = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            ans_q <= 32'h0;
        end else begin
            ans_q <= ans_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // events

    logic conflict_ev;
    logic param_ev;

    // explicit resolution outside what this range offers
    assign conflict_ev = cmd_wr && op == ACVR_OP_RES_SET && sel == ACVR_SEL_NUM && !res_fits;
    assign param_ev = cmd_wr && (((op == ACVR_OP_RANGE_SET || op == ACVR_OP_CONF) && !num_ok)
        || (op == ACVR_OP_AUTO_SET && arg > 24'h000001));

    logic [3:0] ev;
    logic [3:0] stat_q;
    logic [3:0] mask_q;
    logic stat_rd;

    assign ev[ACVR_EV_ANS] = ans_ev;
    assign ev[ACVR_EV_CONFLICT] = conflict_ev;
    assign ev[ACVR_EV_PARAM] = param_ev;
    assign ev[ACVR_EV_AUTOSW] = auto_switch;
    assign stat_rd = reg_rd && (reg_addr == ACVR_STAT_OFS);

    // read clears; a new event in the same cycle stays set
    always_ff @(posedge ref_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            stat_q <= 4'h0;
        end else begin
            stat_q <= (stat_rd ? 4'h0 : stat_q) | ev;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            mask_q <= ACVR_MASK_RST;
        end else if (reg_wr && reg_addr == ACVR_MASK_OFS) begin
            mask_q <= reg_wdata[3:0];
        end
    end

    assign irq = |(stat_q & mask_q);

    ////////////////////////////////////////////////////////////////////////////
    // read port and measurement handoff

    logic [31:0] rdata_q;

    always_ff @(posedge ref_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            rdata_q <= 32'h0;
        end else if (reg_rd) begin
            unique case (reg_addr)
                ACVR_ANS_OFS: rdata_q <= ans_q;
                ACVR_SET_OFS: rdata_q <= {res_exp, 16'h0, 1'b0, auto_q, res_step_q, 1'b0, range_q};
                ACVR_STAT_OFS: rdata_q <= {28'h0, stat_q};
                ACVR_MASK_OFS: rdata_q <= {28'h0, mask_q};
                default: rdata_q <= 32'h0;
            endcase
        end else begin
            rdata_q <= 32'h0;
        end
    end

    logic go_q;

    // reading starts the cycle after the request, on the settled range
    always_ff @(posedge ref_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            go_q <= 1'b0;
        end else begin
            go_q <= meas_req;
        end
    end

    assign reg_rdata = rdata_q;
    assign meas_go = go_q;
    assign range_idx = range_q;
    assign autorange_on = auto_q;
    assign res_exp = best_exp(range_q) + {6'h0, res_step_q};

endmodule : acvr_ctl

// ===== acvr_ctl_sva.sv
// acvr_ctl_sva: port-level checks for the ac volt settings block.
// assumes one clock domain; bound onto acvr_ctl from the bench top.
module acvr_ctl_sva
    import acvr_pkg::*;
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic reset_n,
    // register port
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [31:0] reg_rdata,
    // measurement path
    input wire logic meas_req,
    input wire logic [2:0] meas_need_range,
    input wire logic meas_go,
    input wire logic [2:0] range_idx,
    input wire logic [7:0] res_exp,
    input wire logic autorange_on,
    // interrupt
    input wire logic irq
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!reset_n);
    logic cmd_wr;
    logic [3:0] op;
    logic [1:0] sel;
    logic signed [7:0] best;
    assign cmd_wr = reg_wr && reg_addr == ACVR_CMD_OFS;
    assign op = reg_wdata[3:0];
    assign sel = reg_wdata[5:4];
    // 300V range shares the 100V decade
    assign best = (range_idx == 3'h4) ? 8'hfc : {5'h0, range_idx} - 8'h07;
    ////////////////////////////////////////
    property p_go; meas_req |=> meas_go; endproperty
    a_go: assert property (p_go) else $error("no start after request");
    property p_go_cause; meas_go |-> $past(meas_req); endproperty
    a_go_cause: assert property (p_go_cause) else $error("stray start");
    property p_rdata; !$past(reg_rd) |-> reg_rdata == 32'h0; endproperty
    a_rdata: assert property (p_rdata) else $error("read data outside slot");
    property p_rst; $rose(reset_n) |-> range_idx == 3'h2 && autorange_on; endproperty
    a_rst: assert property (p_rst) else $error("bad settings after reset");
    property p_sel_range;
        cmd_wr && op == 4'h1 && sel != 2'h0 |=>
            range_idx == ($past(sel) == 2'h1 ? 3'h0 : $past(sel) == 2'h2 ? 3'h4 : 3'h2);
    endproperty
    a_sel_range: assert property (p_sel_range) else $error("selector range wrong");
    property p_fix_off; cmd_wr && op == 4'h1 && sel != 2'h0 |=> !autorange_on; endproperty
    a_fix_off: assert property (p_fix_off) else $error("autorange kept on");
    property p_auto_set;
        cmd_wr && op == 4'h3 && sel == 2'h0 && reg_wdata[31:9] == 23'h0 |=>
            autorange_on == $past(reg_wdata[8]);
    endproperty
    a_auto_set: assert property (p_auto_set) else $error("autorange not set");
    property p_follow;
        autorange_on && meas_req && meas_need_range <= 3'h4 && !cmd_wr |=>
            range_idx == $past(meas_need_range);
    endproperty
    a_follow: assert property (p_follow) else $error("autorange did not follow");
    property p_res_win; $signed(res_exp) >= best && $signed(res_exp) <= best + 8'sh02; endproperty
    a_res_win: assert property (p_res_win) else $error("resolution off range");
    property p_irq_mask; reg_wr && reg_addr == ACVR_MASK_OFS && reg_wdata[3:0] == 4'h0 |=> !irq;
    endproperty
    a_irq_mask: assert property (p_irq_mask) else $error("irq while masked");
    c_auto: cover property (meas_req && autorange_on);
    c_irq: cover property (irq);
    c_res: cover property (cmd_wr && op == 4'h5);
endmodule : acvr_ctl_sva

// ===== acvr_meas_model.sv
// acvr_meas_model: measurement path stand-in that asks for a range.
// assumes the bench pulses trig for one cycle per wanted reading.
module acvr_meas_model (
    // clock
    input wire logic ref_clk,
    // bench control
    input wire logic trig,
    input wire logic [2:0] need,
    // to the block
    output logic meas_req,
    output logic [2:0] meas_need_range
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        meas_req = 1'b0;
        meas_need_range = 3'h0;
    end
    always @(posedge ref_clk) begin
        meas_req <= trig;
        // idle lines toggle so a stale value is never trusted
        meas_need_range <= trig ? need : ~meas_need_range;
    end
endmodule : acvr_meas_model

// ===== acvr_ctl_tb.sv
// acvr_ctl_tb: self-checking bench for the ac volt settings block.
// assumes 50 MHz ref_clk and the register map of acvr_pkg.
`define CHK(nm, e, a) begin total_checks++; if ((a) !== (e)) begin error_cnt++; \
    $display("CHECK FAILED %s exp %h got %h", nm, e, a); end end
module acvr_ctl_tb
    import acvr_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct {logic [31:0] cmd; logic [7:0] addr; logic [31:0] exp;} acvr_row_t;
    logic ref_clk = 1'b0;
    logic reset_n = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic trig = 1'b0;
    logic [2:0] need = 3'h0;
    logic [31:0] reg_rdata;
    logic meas_req, meas_go, autorange_on, irq;
    logic [2:0] meas_need_range, range_idx;
    logic [7:0] res_exp;
    int error_cnt = 0;
    int total_checks = 0;
    // command word, register read back, expected word
    // no aperture request is ever made; fixed ranges come first
    acvr_row_t rows [20] = '{
        '{32'h0003b601, 8'h08, 32'hfb000011}, '{32'h00000002, 8'h04, 32'h000003e8},
        '{32'h00000103, 8'h08, 32'hfb000051}, '{32'h00000004, 8'h04, 32'h00000001},
        '{32'h00000011, 8'h08, 32'hfa000010}, '{32'h00000022, 8'h04, 32'h000493e0},
        '{32'h00000025, 8'h08, 32'hfb000020}, '{32'h00000006, 8'h04, 32'hfffffffb},
        '{32'h00000021, 8'h08, 32'hfe000024}, '{32'h00000031, 8'h08, 32'hfd000022},
        '{32'h0000fb05, 8'h08, 32'hfb000002}, '{32'h00000016, 8'h04, 32'hfffffffb},
        '{32'h0493e101, 8'h08, 32'hfb000002}, '{32'h0493e001, 8'h08, 32'hfc000004},
        '{32'h00000001, 8'h08, 32'hf9000000}, '{32'h0000fc05, 8'h08, 32'hf9000000},
        '{32'h00000004, 8'h04, 32'h00000000}, '{32'h00000203, 8'h08, 32'hf9000000},
        '{32'h00000012, 8'h04, 32'h00000064}, '{32'h00000006, 8'h04, 32'hfffffff9}};
    acvr_ctl u_acvr_ctl (.ref_clk, .reset_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
        .reg_rdata, .meas_req, .meas_need_range, .meas_go, .range_idx, .res_exp,
        .autorange_on, .irq);
    acvr_meas_model u_acvr_meas_model (.ref_clk, .trig, .need, .meas_req, .meas_need_range);
    ////////////////////////////////////////
    initial begin
        forever #10 ref_clk = ~ref_clk;
    end
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
        #1;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge ref_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1;
        `CHK("reg_rdata", e, reg_rdata)
    endtask : rd
    task automatic meas(input logic [2:0] n);
        @(posedge ref_clk);
        trig <= 1'b1;
        need <= n;
        @(posedge ref_clk);
        trig <= 1'b0;
        @(posedge ref_clk);
        #1;
        `CHK("meas_go", 1'b1, meas_go)
    endtask : meas
    task automatic report_and_stop();
        if (error_cnt == 0 && total_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : report_and_stop
    // hang guard, far beyond the scripted run
    initial begin
        #100us;
        error_cnt++;
        report_and_stop();
    end
    initial begin
        repeat (3) @(posedge ref_clk);
        reset_n <= 1'b1;
        repeat (3) @(posedge ref_clk);
        rd(8'h08, 32'hfc000052);
        rd(8'h10, 32'h0);
        `CHK("irq", 1'b0, irq)
        foreach (rows[i]) begin
            wr(ACVR_CMD_OFS, rows[i].cmd);
            rd(rows[i].addr, rows[i].exp);
        end
        rd(8'h0c, 32'h7);
        rd(8'h0c, 32'h0);
        rd(8'h14, 32'h0);
        wr(8'h10, 32'h2);
        wr(8'h00, 32'h0000fc05);
        `CHK("irq", 1'b1, irq)
        wr(8'h10, 32'h0);
        `CHK("irq", 1'b0, irq)
        wr(8'h10, 32'h2);
        rd(8'h0c, 32'h2);
        `CHK("irq", 1'b0, irq)
        wr(8'h00, 32'h00000103);
        meas(3'h3);
        `CHK("range_idx", 3'h3, range_idx)
        `CHK("res_exp", 8'hfc, res_exp)
        meas(3'h5);
        `CHK("range_idx", 3'h3, range_idx)
        rd(8'h08, 32'hfc000043);
        rd(8'h0c, 32'h8);
        report_and_stop();
    end
endmodule : acvr_ctl_tb
bind acvr_ctl acvr_ctl_sva u_acvr_ctl_sva (.ref_clk, .reset_n, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata, .meas_req, .meas_need_range, .meas_go, .range_idx, .res_exp,
    .autorange_on, .irq);
